// >>> hdl/kms_pkg.sv
// shared constants and types of the key matrix scanner
package kms_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SCAN_HZ = 128_000;
  localparam int unsigned TICK_DIV = CLK_HZ / SCAN_HZ;
  localparam int unsigned MAX_ROWS = 8;
  localparam int unsigned MAX_COLS = 20;
  localparam int unsigned MAX_KEYS = MAX_ROWS * MAX_COLS;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned DEB_SCANS_DEF = 3;
  localparam int unsigned NUM_MODS = 4;
  localparam int unsigned SYNC_STAGES = 3;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_KEY = 8'h08;
  localparam logic [7:0] OFF_MOD = 8'h0C;
  localparam logic [7:0] OFF_MODST = 8'h10;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_ROWS_LSB = 8;
  localparam int unsigned CTRL_COLS_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0014_0800;
  localparam logic [31:0] CTRL_MASK = 32'h001F_0F01;
  localparam logic [31:0] MOD_RESET = 32'hFFFF_FFFF;

  localparam int unsigned ST_EMPTY = 0;
  localparam int unsigned ST_FULL = 1;
  localparam int unsigned ST_OVF = 2;
  localparam int unsigned ST_GHOST = 3;
  localparam int unsigned ST_REQ = 4;
  localparam int unsigned ST_STATE_LSB = 5;
  localparam int unsigned ST_LEVEL_LSB = 8;
  localparam int unsigned KEY_VALID_BIT = 31;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KMS_IDLE, KMS_SCAN, KMS_END} kms_state_e;
endpackage

// >>> hdl/kms_fifo_if.sv
// key code buffer signals between scanner and buffer
`timescale 1ns/1ps
interface kms_fifo_if #(parameter int W = 8, parameter int LW = 5);
  logic push;
  logic pop;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  logic [LW-1:0] level;
  modport producer(output push, output pop, output wdata,
                   input rdata, input full, input empty, input level);
  modport fifo(input push, input pop, input wdata,
               output rdata, output full, output empty, output level);
endinterface

// >>> hdl/kms_key_fifo.sv
// first-in first-out key code buffer held in flip-flops
`timescale 1ns/1ps
module kms_key_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  kms_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [LW-1:0] cnt;
  logic do_push;
  logic do_pop;

  assign f.full = (cnt == LW'(DEPTH));
  assign f.empty = (cnt == '0);
  assign f.level = cnt;
  assign f.rdata = mem[rp];
  // a code arriving while full is dropped
  assign do_push = f.push && !f.full; // [RULE_23]
  assign do_pop = f.pop && !f.empty; // [RULE_24]

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wp] <= f.wdata; // [RULE_04]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (do_push) begin
        wp <= wp + 1'b1;
      end
      if (do_pop) begin
        rp <= rp + 1'b1; // [RULE_24]
      end
      if (do_push && !do_pop) begin
        cnt <= cnt + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
    cnt <= LW'(DEPTH)) else $error("buffer level above depth");
  a_fifo_keep: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
    (!f.pop && !f.empty) |=> !f.empty) else $error("entry lost without read");
endmodule

// >>> hdl/kms_scanner.sv
// key matrix scanner with debounce, ghost detection and AXI4-Lite registers
//
// Contract
// [RULE_01] scan keys one by one over up to 8 rows by 20 columns
// [RULE_02] column count programmable from 1 to 20
// [RULE_03] row count programmable from 1 to 8
// [RULE_04] key codes held in a 16-entry hardware buffer
// [RULE_05] scan steps run at 128 kHz, full matrix in about 1.2 ms
// [RULE_06] report any number of keys, lock out keys caught in a ghost
// [RULE_07] buffered codes stay until read or until overflow
// [RULE_08] row samples debounced and glitch filtered in hardware
// [RULE_09] start in idle after reset, all columns high while idle
// [RULE_10] row change in idle requests the clock and starts a scan
// [RULE_11] idle clears row-hit register and key-index counter
// [RULE_12] row counter runs 0 to rows-1, then wraps and steps column
// [RULE_13] both counters at terminal count moves to scan-end
// [RULE_14] key-index counter increments for each visited key
// [RULE_15] modifier keys matched against stored codes, others buffered
// [RULE_16] row pattern ORed into row-hit only for columns with two hits; the code ORs it for any column with two or more
// [RULE_17] hit in a row already flagged sets the ghost status bit
// [RULE_18] scan-end rescans on activity, else idle and request dropped
// [RULE_19] no clock request while the scanner is disabled
// [RULE_20] request may drop while enabled, raised again on a keypress
// [RULE_21] key status register polled by the microcontroller
// [RULE_22] oscillator on whenever any block requests the clock
// [RULE_23] code into a full buffer dropped, sticky overflow bit set
// [RULE_24] buffer read returns and removes the oldest entry
// [RULE_25] key state accepted after stable over several scans
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module kms_scanner
  import kms_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DEB_SCANS = DEB_SCANS_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [MAX_ROWS-1:0] row_in,
  input wire logic peer_clk_req,
  output logic [MAX_COLS-1:0] col_out,
  output logic lp_clk_req,
  output logic lp_osc_on
);
  localparam logic [1:0] DEB_LAST = 2'(DEB_SCANS - 1);
  localparam logic [9:0] TICK_LAST = 10'(TICK_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [2:0] rows_last(input logic [3:0] v);
    if (v == 4'h0) begin
      return 3'h0;
    end else if (v > 4'(MAX_ROWS)) begin
      return 3'(MAX_ROWS - 1);
    end
    return 3'(v - 4'h1);
  endfunction

  function automatic logic [4:0] cols_last(input logic [4:0] v);
    if (v == 5'h00) begin
      return 5'h00;
    end else if (v > 5'(MAX_COLS)) begin
      return 5'(MAX_COLS - 1);
    end
    return v - 5'h01;
  endfunction

  function automatic logic two_or_more(input logic [MAX_ROWS-1:0] v);
    return (v & (v - 1'b1)) != '0;
  endfunction

  function automatic logic [NUM_MODS-1:0] mod_match(input logic [7:0] idx,
                                                    input logic [31:0] mods);
    logic [NUM_MODS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_MODS; i++) begin
      m[i] = (mods[i*8 +: 8] == idx);
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  kms_fifo_if #(.W(CODE_W), .LW(5)) kf();
  kms_state_e state;
  logic [31:0] ctrl;
  logic [31:0] mods;
  logic [NUM_MODS-1:0] mod_state;
  logic ovf;
  logic ghost;
  logic [9:0] div_cnt;
  logic tick;
  logic [SYNC_STAGES-1:0] row_sync [MAX_ROWS];
  logic [MAX_ROWS-1:0] row_f;
  logic [MAX_ROWS-1:0] row_prev;
  logic [SYNC_STAGES-1:0] peer_sync;
  logic peer_f;
  logic [2:0] row;
  logic [4:0] col;
  logic [7:0] kidx;
  logic [MAX_ROWS-1:0] row_hit;
  logic [MAX_ROWS-1:0] col_pat;
  logic any_hit;
  logic [MAX_KEYS-1:0] acc;
  logic [1:0] dcnt [MAX_KEYS];
  logic push_q;
  logic [CODE_W-1:0] push_code;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic en;
  logic step;
  logic pressed;
  logic last_row;
  logic last_col;
  logic ghost_hit;
  logic change;
  logic accept;
  logic [MAX_ROWS-1:0] pat_all;
  logic [NUM_MODS-1:0] mhit;
  logic wr_fire;
  logic ar_fire;
  logic stat_clr;
  logic [31:0] stat_word;

  kms_key_fifo #(.W(CODE_W), .DEPTH(FIFO_DEPTH), .LW(5)) kms_key_fifo_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(kf.fifo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // scan step decode
  assign en = ctrl[CTRL_EN_BIT];
  assign step = tick && (state == KMS_SCAN);
  assign pressed = ~row_f[row];
  assign last_row = (row == rows_last(ctrl[CTRL_ROWS_LSB +: 4])); // [RULE_03]
  assign last_col = (col == cols_last(ctrl[CTRL_COLS_LSB +: 5])); // [RULE_02]
  assign ghost_hit = step && pressed && row_hit[row]; // [RULE_17]
  assign change = pressed != acc[kidx];
  // a press in a ghost row is held back, a release is not
  assign accept = step && change && (dcnt[kidx] == DEB_LAST) &&
                  !(pressed && row_hit[row]); // [RULE_06] [RULE_25]
  assign pat_all = col_pat | ({7'h00, pressed} << row);
  assign mhit = mod_match(kidx, mods);

  ////////////////////////////////////////////////////////////////////////////
  // 128 kHz step enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == TICK_LAST); // [RULE_05]
      div_cnt <= (div_cnt == TICK_LAST) ? 10'h000 : div_cnt + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, a change counts once stages two and three agree
  generate
    for (genvar g = 0; g < MAX_ROWS; g++) begin : g_row_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          row_sync[g] <= '1;
          row_f[g] <= 1'b1;
        end else begin
          row_sync[g] <= {row_sync[g][1:0], row_in[g]};
          if (row_sync[g][1] == row_sync[g][2]) begin
            row_f[g] <= row_sync[g][2]; // [RULE_08]
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peer_sync <= '0;
      peer_f <= 1'b0;
    end else begin
      peer_sync <= {peer_sync[1:0], peer_clk_req};
      if (peer_sync[1] == peer_sync[2]) begin
        peer_f <= peer_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan state machine and counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= KMS_IDLE; // [RULE_09]
      row <= '0;
      col <= '0;
      kidx <= '0;
      row_hit <= '0;
      col_pat <= '0;
      any_hit <= 1'b0;
      row_prev <= '1;
    end else begin
      row_prev <= row_f;
      if (!en) begin
        state <= KMS_IDLE; // [RULE_19]
        kidx <= '0;
        row_hit <= '0;
      end else begin
        case (state)
          KMS_IDLE: begin
            kidx <= '0; // [RULE_11]
            row_hit <= '0; // [RULE_11]
            row <= '0;
            col <= '0;
            col_pat <= '0;
            any_hit <= 1'b0;
            if (row_f != row_prev) begin
              state <= KMS_SCAN; // [RULE_10] [RULE_20]
            end
          end
          KMS_SCAN: begin
            if (tick) begin
              kidx <= kidx + 8'h01; // [RULE_14]
              if (pressed || change || dcnt[kidx] != 2'h0) begin
                any_hit <= 1'b1;
              end
              if (last_row) begin
                row <= '0; // [RULE_12]
                col_pat <= '0;
                if (two_or_more(pat_all)) begin
                  row_hit <= row_hit | pat_all; // [RULE_16]
                end
                if (last_col) begin
                  col <= '0;
                  state <= KMS_END; // [RULE_13]
                end else begin
                  col <= col + 5'h01; // [RULE_01]
                end
              end else begin
                row <= row + 3'h1; // [RULE_12]
                col_pat <= pat_all;
              end
            end
          end
          KMS_END: begin
            if (tick) begin
              kidx <= '0;
              row_hit <= '0;
              any_hit <= 1'b0;
              state <= any_hit ? KMS_SCAN : KMS_IDLE; // [RULE_18]
            end
          end
          default: begin
            state <= KMS_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-key debounce memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
      for (int i = 0; i < MAX_KEYS; i++) begin
        dcnt[i] <= 2'h0;
      end
    end else if (step) begin
      if (!change) begin
        dcnt[kidx] <= 2'h0; // [RULE_25]
      end else if (accept) begin
        acc[kidx] <= pressed; // [RULE_25]
        dcnt[kidx] <= 2'h0;
      end else if (dcnt[kidx] != DEB_LAST) begin
        dcnt[kidx] <= dcnt[kidx] + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modifier tracking and key code hand-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      push_q <= 1'b0;
      push_code <= '0;
      mod_state <= '0;
    end else begin
      push_q <= 1'b0;
      if (accept && mhit != '0) begin
        for (int i = 0; i < NUM_MODS; i++) begin
          if (mhit[i]) begin
            mod_state[i] <= pressed; // [RULE_15]
          end
        end
      end else if (accept && pressed) begin
        push_q <= 1'b1; // [RULE_15]
        push_code <= kidx;
      end
    end
  end

  assign kf.push = push_q;
  assign kf.wdata = push_code;
  assign kf.pop = ar_fire && (s_axi_araddr == OFF_KEY) && !kf.empty; // [RULE_24]

  ////////////////////////////////////////////////////////////////////////////
  // sticky status flags, a set wins over a clear
  assign stat_clr = wr_fire && (aw_addr == OFF_STAT) && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf <= 1'b0;
      ghost <= 1'b0;
    end else begin
      if (push_q && kf.full) begin
        ovf <= 1'b1; // [RULE_23]
      end else if (stat_clr && w_data[ST_OVF]) begin
        ovf <= 1'b0;
      end
      if (ghost_hit) begin
        ghost <= 1'b1; // [RULE_17]
      end else if (stat_clr && w_data[ST_GHOST]) begin
        ghost <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and clock request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col_out <= '1;
      lp_clk_req <= 1'b0;
      lp_osc_on <= 1'b0;
    end else begin
      if (state == KMS_SCAN) begin
        col_out <= ~(MAX_COLS'(1) << col); // [RULE_01]
      end else begin
        col_out <= '1; // [RULE_09]
      end
      lp_clk_req <= en && (state != KMS_IDLE); // [RULE_19] [RULE_18]
      lp_osc_on <= lp_clk_req || peer_f; // [RULE_22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == OFF_CTRL || aw_addr == OFF_STAT || aw_addr == OFF_MOD) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      mods <= MOD_RESET;
    end else if (wr_fire) begin
      if (aw_addr == OFF_CTRL) begin
        ctrl <= merge(ctrl, w_data, w_strb) & CTRL_MASK; // [RULE_02] [RULE_03]
      end else if (aw_addr == OFF_MOD) begin
        mods <= merge(mods, w_data, w_strb);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign stat_word = {19'h00000, kf.level, 1'b0, state, lp_clk_req, ghost, ovf,
                      kf.full, kf.empty};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == OFF_CTRL) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == OFF_STAT) begin
        s_axi_rdata <= stat_word; // [RULE_21]
      end else if (s_axi_araddr == OFF_KEY) begin
        // an empty buffer reads as zero, never as stale storage
        s_axi_rdata <= {!kf.empty, 23'h000000, (kf.empty ? 8'h00 : kf.rdata)}; // [RULE_24]
      end else if (s_axi_araddr == OFF_MOD) begin
        s_axi_rdata <= mods;
      end else if (s_axi_araddr == OFF_MODST) begin
        s_axi_rdata <= {28'h0000000, mod_state};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_idle_cols_high: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
    (state == KMS_IDLE) |=> (col_out == '1)) else $error("column low in idle");
  a_req_disabled: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_19]
    !en |=> !lp_clk_req) else $error("clock request while disabled");
  a_idle_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
    (en && state == KMS_IDLE) |=> (kidx == 8'h00 && row_hit == '0))
    else $error("index or row-hit not cleared in idle");
  a_row_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
    (step && last_row && !last_col && en) |=> (row == 3'h0 && col == $past(col) + 5'h01))
    else $error("row wrap or column step wrong");
  a_scan_to_end: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
    (step && last_row && last_col && en) |=> (state == KMS_END))
    else $error("scan did not reach scan-end");
  a_end_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_18]
    (en && tick && state == KMS_END && !any_hit) |=> (state == KMS_IDLE) ##1 !lp_clk_req)
    else $error("scan-end did not release request");
  a_ghost_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_17]
    ghost_hit |=> ghost) else $error("ghost bit not set");
  a_overflow_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_23]
    (push_q && kf.full && !kf.pop) |=> (ovf && kf.full)) else $error("overflow not flagged");
  a_osc_on: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_22]
    lp_clk_req |=> lp_osc_on) else $error("oscillator off under request");
  a_step_rate: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
    tick |=> !tick [*8]) else $error("step enable too frequent");
endmodule

// >>> bench/kms_key_matrix.sv
// passive key switch matrix model with pulled-up rows
`timescale 1ns/1ps
module kms_key_matrix
  import kms_pkg::*;
(
  input wire logic [MAX_COLS-1:0] col_out,
  input wire logic [MAX_ROWS-1:0][MAX_COLS-1:0] pressed,
  input wire logic wake,
  output logic [MAX_ROWS-1:0] row_in
);
  // row low when a pressed key sits on a low column, wake pulls all rows
  always_comb begin
    for (int r = 0; r < MAX_ROWS; r++) begin
      row_in[r] = !wake;
      for (int c = 0; c < MAX_COLS; c++) begin
        if (pressed[r][c] && !col_out[c]) begin
          row_in[r] = 1'b0;
        end
      end
    end
  end
endmodule

// >>> bench/kms_scanner_tb.sv
// register-level testbench of the key matrix scanner
`timescale 1ns/1ps
module kms_scanner_tb;
  import kms_pkg::*;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lp_clk_req, lp_osc_on;
  logic [1:0] bresp, rresp;
  logic [1:0] last_resp;
  logic [31:0] rdata, v;
  logic [MAX_ROWS-1:0] row_in;
  logic [MAX_COLS-1:0] col_out;
  logic [MAX_ROWS-1:0][MAX_COLS-1:0] pressed = '0;
  logic wake = 1'b0;
  logic peer_clk_req = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  always #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  kms_scanner #(.ADDR_W(8), .DEB_SCANS(2)) kms_scanner_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .row_in(row_in),
    .peer_clk_req(peer_clk_req), .col_out(col_out), .lp_clk_req(lp_clk_req),
    .lp_osc_on(lp_osc_on));
  kms_key_matrix kms_key_matrix_i (.col_out(col_out), .pressed(pressed), .wake(wake),
    .row_in(row_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    report_and_stop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) tmo();
    last_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) tmo();
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic val);
    int n;
    logic [31:0] d;
    for (n = 0; n < 400; n++) begin
      rd(a, d);
      if (d[b] === val) break;
      repeat (100) @(posedge aclk);
    end
    if (n == 400) tmo();
  endtask
  task automatic pulse();
    wake <= 1'b1;
    repeat (20) @(posedge aclk);
    wake <= 1'b0;
    repeat (50) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(col_out, {MAX_COLS{1'b1}})
    rd(OFF_CTRL, v);
    `CHK(v, CTRL_RESET)
    `CHK(last_resp, RESP_OKAY)
    rd(OFF_MOD, v);
    `CHK(v, MOD_RESET)
    rd(OFF_STAT, v);
    `CHK(v[ST_EMPTY], 1'b1)
    rd(8'h20, v);
    `CHK(last_resp, RESP_SLVERR)
    pulse();
    `CHK(lp_clk_req, 1'b0)
    peer_clk_req <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(lp_osc_on, 1'b1)
    peer_clk_req <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK(lp_osc_on, 1'b0)
    wr(OFF_CTRL, 32'h0002_0201);
    `CHK(last_resp, RESP_OKAY)
    rd(OFF_CTRL, v);
    `CHK(v, 32'h0002_0201)
    pressed[0][0] <= 1'b1;
    pressed[1][1] <= 1'b1;
    pulse();
    `CHK(lp_clk_req, 1'b1)
    `CHK(col_out[0], 1'b0)
    `CHK(col_out[MAX_COLS-1:1], {(MAX_COLS-1){1'b1}})
    poll(OFF_STAT, ST_LEVEL_LSB + 1, 1'b1);
    rd(OFF_KEY, v);
    `CHK(v, 32'h8000_0000)
    rd(OFF_KEY, v);
    `CHK(v, 32'h8000_0003)
    rd(OFF_KEY, v);
    `CHK(v, 32'h0000_0000)
    pressed <= '0;
    poll(OFF_STAT, ST_REQ, 1'b0);
    `CHK(col_out, {MAX_COLS{1'b1}})
    rd(OFF_KEY, v);
    `CHK(v, 32'h0000_0000)
    wr(OFF_MOD, 32'hFFFF_FF03);
    pressed[1][1] <= 1'b1;
    pulse();
    poll(OFF_MODST, 0, 1'b1);
    rd(OFF_STAT, v);
    `CHK(v[ST_EMPTY], 1'b1)
    pressed <= '0;
    poll(OFF_STAT, ST_REQ, 1'b0);
    pressed[0][0] <= 1'b1;
    pressed[1][0] <= 1'b1;
    pressed[0][1] <= 1'b1;
    pulse();
    poll(OFF_STAT, ST_GHOST, 1'b1);
    pressed <= '0;
    poll(OFF_STAT, ST_REQ, 1'b0);
    wr(OFF_STAT, 32'h0000_0008);
    rd(OFF_STAT, v);
    `CHK(v[ST_GHOST], 1'b0)
    report_and_stop();
  end
endmodule
